//--- dac_link_pkg.sv
// Shared constants for the serial DAC input link and its host controller
//==========================================================================
// Functional notes
// - Falling frame select starts a write frame
// - Sample data on falling shift clock edges
// - Apply frame on twenty-fourth falling edge
// - Host holds select high before next frame
// - Host shift clock at most 30 MHz
// - Host may idle select low between frames
// - First six frame bits are ignored
// - Next two bits select operating mode
// - Last sixteen bits load the code register
// - Early select rise discards the frame
// - Power-up output code held until frame
// - Mode encodings: normal, 1k, 100k, open
// - Power-down disconnects output, applies termination
// - Power-down keeps stored code unchanged
// - Output valid 4 us after wake-up
// - Code is unsigned straight binary
// - Host sends most significant bit first
// - Select stays low across byte transfers
// - Data stable at falling clock edge
package dac_link_pkg;
    //======================================================================
    // Frame layout
    localparam int FRAME_BITS    = 24;
    localparam int CODE_BITS     = 16;
    localparam int MODE_HI_POS   = 17;
    localparam int MODE_LO_POS   = 16;
    localparam int COUNT_W       = 5;

    // Operating modes carried in the frame
    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_PD_1K    = 2'b01,
        MODE_PD_100K  = 2'b10,
        MODE_PD_OPEN  = 2'b11
    } op_mode_e;

    //======================================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SEL_HIGH_NS     = 33;
    localparam int SEL_HIGH_CYC    = (SEL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_US         = 4;
    localparam int WAKE_CYC        = WAKE_US * 1000 / CLK_PERIOD_NS;
    localparam int SCLK_MAX_MHZ    = 30;
    localparam int SCLK_MIN_HALF   = (1000 / SCLK_MAX_MHZ / 2 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int HOST_HALF_DEF   = 6;

    //======================================================================
    // Power-up codes and host register map
    localparam logic [15:0] CODE_ZERO  = 16'h0000;
    localparam logic [15:0] CODE_MID   = 16'h8000;
    localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
    localparam logic [31:0] REG_DATA   = 32'h0000_0004;
    localparam logic [31:0] REG_STATUS = 32'h0000_0008;
    localparam int          CTRL_GO    = 0;
    localparam int          CTRL_IDLE  = 1;
    localparam int          CTRL_ABORT = 2;
    localparam int          CTRL_ACNT  = 8;
    localparam int          STAT_BUSY  = 0;
endpackage

//--- dac_link_if.sv
// Three-wire link between host controller and DAC front end
interface dac_link_if;
    logic sync_n;   // Frame select, active low
    logic sclk;     // Shift clock
    logic din;      // Serial data
    modport host   (output sync_n, output sclk, output din);
    modport device (input sync_n, input sclk, input din);
endinterface

//--- dac_front_end.sv
// DAC front end: frame receiver, code register, mode and output control
module dac_front_end
    import dac_link_pkg::*;
#(
    parameter logic        MIDSCALE_VARIANT = 1'b0,
    parameter int          WAKE_CYCLES      = WAKE_CYC
) (
    input  wire logic        core_clk,      // System clock
    input  wire logic        rstn,          // Sync reset, active low
    dac_link_if.device       link,          // Serial link
    output logic [15:0]      dac_code,      // Stored code register
    output logic [1:0]       op_mode,       // Applied operating mode
    output logic             amp_connect,   // Amplifier drives the output pin
    output logic             term_1k,       // 1k termination to ground
    output logic             term_100k,     // 100k termination to ground
    output logic             output_valid,  // Output settled and driven
    output logic             frame_done     // Pulse when a frame applies
);
    //======================================================================
    // State
    typedef struct packed {
        logic [1:0]         sync_s;
        logic [1:0]         sclk_s;
        logic [1:0]         din_s;
        logic               sync_q;
        logic               sclk_q;
        logic               armed;
        logic [COUNT_W-1:0] cnt;
        logic [23:0]        shreg;
        logic [15:0]        code;
        logic [1:0]         mode;
        logic [15:0]        wake;
        logic               valid;
        logic               done;
    } state_s;

    state_s st;
    state_s next_st;

    //======================================================================
    // Next-state logic
    always_comb begin
        logic fall_sclk;
        logic fall_sync;
        logic [23:0] word;
        fall_sclk = 1'b0;
        fall_sync = 1'b0;
        word      = '0;
        next_st   = st;
        next_st.sync_s = {st.sync_s[0], link.sync_n};
        next_st.sclk_s = {st.sclk_s[0], link.sclk};
        next_st.din_s  = {st.din_s[0], link.din};
        // Edges taken only from the second synchroniser stage
        next_st.sync_q = st.sync_s[1];
        next_st.sclk_q = st.sclk_s[1];
        next_st.done   = 1'b0;
        fall_sclk = st.sclk_q & ~st.sclk_s[1];
        fall_sync = st.sync_q & ~st.sync_s[1];
        if (st.sync_s[1]) begin
            // Select high: partial frame is dropped
            next_st.armed = 1'b0;
            next_st.cnt   = '0;
            next_st.shreg = '0;
        end else if (fall_sync) begin
            next_st.armed = 1'b1;
            next_st.cnt   = '0;
        end else if (st.armed && fall_sclk) begin
            // Data line is two stages behind too, so it lines up with the clock
            word = {st.shreg[22:0], st.din_s[1]};
            next_st.shreg = word;
            if (st.cnt == COUNT_W'(FRAME_BITS - 1)) begin
                // First six bits simply fall off the top unused
                // Power-down frames leave the stored code untouched
                if ({word[MODE_HI_POS], word[MODE_LO_POS]} == MODE_NORMAL) begin
                    next_st.code = word[CODE_BITS-1:0];
                end
                next_st.mode  = {word[MODE_HI_POS], word[MODE_LO_POS]};
                next_st.done  = 1'b1;
                next_st.armed = 1'b0;
                if (st.mode != MODE_NORMAL &&
                    {word[MODE_HI_POS], word[MODE_LO_POS]} == MODE_NORMAL) begin
                    next_st.wake  = 16'(WAKE_CYCLES);
                    next_st.valid = 1'b0;
                end
            end else begin
                next_st.cnt = st.cnt + COUNT_W'(1);
            end
        end
        // Wake-up countdown after leaving power-down
        if (st.mode != MODE_NORMAL) begin
            next_st.valid = 1'b0;
        end else if (st.wake != 16'h0000 && !next_st.done) begin
            next_st.wake = st.wake - 16'h0001;
            next_st.valid = (st.wake == 16'h0001);
        end
    end

    //======================================================================
    // Register stage; reset forces the power-up code and normal mode
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st       <= '0;
            st.sync_s <= 2'b11;
            st.sync_q <= 1'b1;
            // Clock idles high, so no false edge follows reset
            st.sclk_s <= 2'b11;
            st.sclk_q <= 1'b1;
            st.code  <= MIDSCALE_VARIANT ? CODE_MID : CODE_ZERO;
            st.mode  <= MODE_NORMAL;
            st.valid <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    //======================================================================
    // Output stage; the code survives any power-down untouched
    assign dac_code     = st.code;
    assign op_mode      = st.mode;
    assign amp_connect  = (st.mode == MODE_NORMAL);
    assign term_1k      = (st.mode == MODE_PD_1K);
    assign term_100k    = (st.mode == MODE_PD_100K);
    assign output_valid = st.valid;
    assign frame_done   = st.done;
endmodule

//--- dac_host_ctrl.sv
// Host end: APB slave registers driving the three-wire frame sender
module dac_host_ctrl
    import dac_link_pkg::*;
#(
    parameter int HALF_CYCLES = HOST_HALF_DEF
) (
    input  wire logic        core_clk,  // System clock
    input  wire logic        rstn,      // Sync reset, active low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB direction
    input  wire logic [31:0] paddr,     // APB address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic [31:0]      prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error
    dac_link_if.host         link       // Serial link
);
    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_GAP   = 2'b01,
        H_SHIFT = 2'b10,
        H_END   = 2'b11
    } hstate_e;

    typedef struct packed {
        hstate_e     fsm;
        logic [23:0] data;
        logic        idle_low;
        logic [4:0]  abort_at;
        logic [7:0]  tmr;
        logic [4:0]  bit_cnt;
        logic        sync_n;
        logic        sclk;
        logic        din;
        logic [31:0] rdata;
    } hst_s;

    // Half period never shorter than the link clock limit allows
    localparam int HALF = (HALF_CYCLES < SCLK_MIN_HALF) ? SCLK_MIN_HALF : HALF_CYCLES;

    hst_s st;
    hst_s next_st;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
        return a[7:0] == r[7:0];
    endfunction

    //======================================================================
    // Register access and frame sequencer
    always_comb begin
        logic wr;
        wr      = psel & penable & pwrite;
        next_st = st;
        if (psel && !penable) begin
            next_st.rdata = 32'h0000_0000;
            if (hit(paddr, REG_DATA)) next_st.rdata = {8'h00, st.data};
            if (hit(paddr, REG_CTRL)) next_st.rdata = {30'h0, st.idle_low, 1'b0};
            if (hit(paddr, REG_STATUS)) next_st.rdata = {31'h0, st.fsm != H_IDLE};
        end
        if (wr && st.fsm == H_IDLE) begin
            if (hit(paddr, REG_DATA)) next_st.data = pwdata[23:0];
            if (hit(paddr, REG_CTRL)) begin
                next_st.idle_low = pwdata[CTRL_IDLE];
                next_st.abort_at = pwdata[CTRL_ABORT] ? pwdata[CTRL_ACNT +: 5] : 5'd0;
                if (pwdata[CTRL_GO]) begin
                    next_st.fsm    = H_GAP;
                    next_st.sync_n = 1'b1;
                    next_st.tmr    = 8'(SEL_HIGH_CYC);
                end
            end
        end
        case (st.fsm)
            H_IDLE: ;
            H_GAP: begin
                // Select high long enough, then fall starts the frame
                if (st.tmr != 8'h00) next_st.tmr = st.tmr - 8'h01;
                else begin
                    next_st.sync_n  = 1'b0;
                    next_st.sclk    = 1'b1;
                    next_st.din     = st.data[23];
                    next_st.bit_cnt = 5'd0;
                    next_st.tmr     = 8'(HALF);
                    next_st.fsm     = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (st.tmr != 8'h00) next_st.tmr = st.tmr - 8'h01;
                else begin
                    next_st.tmr  = 8'(HALF);
                    next_st.sclk = ~st.sclk;
                    if (st.sclk) begin
                        // Falling edge: device samples the stable bit
                        next_st.bit_cnt = st.bit_cnt + 5'd1;
                        if (st.bit_cnt == 5'(FRAME_BITS - 1))
                            next_st.fsm = H_END;
                    end else if (st.abort_at != 5'd0 && st.bit_cnt == st.abort_at) begin
                        // Abort with the clock back high, so no fall lands outside a frame
                        next_st.sclk   = 1'b1;
                        next_st.sync_n = 1'b1;
                        next_st.fsm    = H_IDLE;
                    end else
                        next_st.din = st.data[5'd23 - st.bit_cnt];
                end
            end
            H_END: begin
                if (st.tmr != 8'h00) next_st.tmr = st.tmr - 8'h01;
                else begin
                    next_st.sclk   = 1'b1;
                    next_st.sync_n = st.idle_low ? 1'b0 : 1'b1;
                    next_st.fsm    = H_IDLE;
                end
            end
            default: next_st.fsm = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st        <= '0;
            st.fsm    <= H_IDLE;
            st.sync_n <= 1'b1;
            st.sclk   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata      = st.rdata;
    assign pready      = psel & penable;
    assign pslverr     = 1'b0;
    assign link.sync_n = st.sync_n;
    assign link.sclk   = st.sclk;
    assign link.din    = st.din;
endmodule

//--- dac_link_chk.sv
// Concurrent checks on the three-wire link and the front end outputs
module dac_link_chk
    import dac_link_pkg::*;
#(
    parameter int WAKE_CYCLES = 10
) (
    input wire logic        core_clk,     // System clock
    input wire logic        rstn,         // Sync reset, active low
    input wire logic        sync_n,       // Frame select
    input wire logic        sclk,         // Shift clock
    input wire logic        din,          // Serial data
    input wire logic [15:0] dac_code,     // Stored code
    input wire logic [1:0]  op_mode,      // Applied mode
    input wire logic        amp_connect,  // Amplifier connected
    input wire logic        term_1k,      // 1k termination
    input wire logic        term_100k,    // 100k termination
    input wire logic        output_valid, // Output settled
    input wire logic        frame_done    // Frame applied
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    localparam int WAKE_LOW = WAKE_CYCLES - 1;
    //======================================================================
    // Falls seen at the pin within a frame, counted at the wire, not as the device sees them
    logic       sclk_q;
    logic [4:0] fall_cnt;
    always_ff @(posedge core_clk) begin
        sclk_q <= sclk;
        if (!rstn || sync_n) fall_cnt <= 5'h00;
        else if (sclk_q && !sclk && fall_cnt != 5'h1f) fall_cnt <= fall_cnt + 5'h01;
    end
    //======================================================================
    // Wire timing and framing
    a_gap_high: assert property ($rose(sync_n) |-> sync_n[*4])
        else $error("select high gap too short");
    a_din_steady: assert property ($fell(sclk) |-> $stable(din))
        else $error("data moved at falling clock");
    a_half_min: assert property ($changed(sclk) |=> $stable(sclk) || sync_n)
        else $error("shift clock half period too short");
    a_fall_in_frame: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock fell outside a frame");
    //======================================================================
    // Applying frames and decoding the mode
    a_apply_at_24: assert property (frame_done |-> fall_cnt == 5'h18)
        else $error("frame applied at wrong edge count");
    a_code_on_apply: assert property ($changed(dac_code) |-> frame_done)
        else $error("code changed without a frame");
    a_mode_on_apply: assert property ($changed(op_mode) |-> frame_done)
        else $error("mode changed without a frame");
    a_term_decode: assert property (amp_connect == (op_mode == MODE_NORMAL)
        && term_1k == (op_mode == MODE_PD_1K) && term_100k == (op_mode == MODE_PD_100K))
        else $error("termination does not match mode");
    a_wake_hold: assert property ($fell(output_valid) |-> !output_valid[*8])
        else $error("output valid too soon after wake");
    a_wake_time: assert property (frame_done && op_mode == MODE_NORMAL
        && $past(op_mode) != MODE_NORMAL |-> ##WAKE_LOW !output_valid ##1 output_valid)
        else $error("output valid at wrong time after wake");
    cover property (frame_done && op_mode == MODE_PD_OPEN);
    cover property ($rose(sync_n) && fall_cnt != 5'h00 && fall_cnt < 5'h18);
    cover property ($rose(output_valid));
endmodule

//--- serial_dac_input_control_tb.sv
// Testbench joining host controller and DAC front end over the link
module serial_dac_input_control_tb
    import dac_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic        pready, pslverr, amp_connect, term_1k, term_100k, output_valid, frame_done;
    logic [15:0] dac_code, last_code = CODE_ZERO, cd;
    logic [1:0]  op_mode, md;
    logic [2:0]  tx;
    int          mismatches = 0, compares = 0;
    typedef struct {logic [15:0] code; logic [1:0] mode; logic use_code;} note_s;
    note_s       notes[$], nt;
    dac_link_if link_w();
    always #5 core_clk = ~core_clk;
    dac_front_end #(.MIDSCALE_VARIANT(1'b0), .WAKE_CYCLES(10)) dac_front_end_i (
        .core_clk(core_clk), .rstn(rstn), .link(link_w), .dac_code(dac_code),
        .op_mode(op_mode), .amp_connect(amp_connect), .term_1k(term_1k),
        .term_100k(term_100k), .output_valid(output_valid), .frame_done(frame_done));
    dac_host_ctrl #(.HALF_CYCLES(3)) dac_host_ctrl_i (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_w));
    dac_link_chk #(.WAKE_CYCLES(10)) dac_link_chk_i (
        .core_clk(core_clk), .rstn(rstn), .sync_n(link_w.sync_n), .sclk(link_w.sclk),
        .din(link_w.din), .dac_code(dac_code), .op_mode(op_mode), .amp_connect(amp_connect),
        .term_1k(term_1k), .term_100k(term_100k), .output_valid(output_valid),
        .frame_done(frame_done));
    //======================================================================
    // Compare, bus cycle and frame tasks
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        // Setup cycle: request and qualifiers stand until pready is seen
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // The slave may stretch the access; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task send(input logic [1:0] m, input logic [15:0] c, input logic [31:0] ctl, input bit ap);
        // A power-down frame must leave the last normal code in place
        if (ap) notes.push_back('{(m == MODE_NORMAL) ? c : last_code, m, 1'b1});
        if (ap && m == MODE_NORMAL) last_code = c;
        apb(1'b1, REG_DATA, {8'h00, 6'($urandom), m, c}, r);
        apb(1'b1, REG_CTRL, ctl | 32'h0000_0001, r);
        repeat (2) @(posedge core_clk);
        r = 32'h0000_0001;
        // Poll until the host is idle; the watchdog covers a hang
        while (r[STAT_BUSY] !== 1'b0) begin
            apb(1'b0, REG_STATUS, 32'h0000_0000, r);
        end
        repeat (30) @(posedge core_clk);
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Result watcher: each applied frame takes the oldest note
    always @(posedge core_clk) begin
        if (frame_done === 1'b1) begin
            if (notes.size() == 0) chk("unexpected frame", 32'h0, 32'h1);
            else begin
                nt = notes.pop_front();
                chk("op_mode", nt.mode, op_mode);
                if (nt.use_code) chk("dac_code", nt.code, dac_code);
                tx = {nt.mode == MODE_NORMAL, nt.mode == MODE_PD_1K, nt.mode == MODE_PD_100K};
                chk("terms", tx, {amp_connect, term_1k, term_100k});
            end
        end
    end
    // Watchdog, far beyond the nine frames of the run
    initial begin
        #200_000;
        mismatches++;
        close_out;
    end
    //======================================================================
    // Main sequence
    initial begin
        void'($urandom(14222));
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("reset code", CODE_ZERO, dac_code);
        chk("reset mode", MODE_NORMAL, op_mode);
        $display("test reset done");
        // Every mode, then wake with a random code and load a full-scale one
        for (int i = 0; i < 6; i++) begin
            md = (i < 4) ? 2'(i) : MODE_NORMAL;
            cd = (i == 5) ? 16'hFFFF : 16'($urandom);
            send(md, cd, 32'h0000_0000, 1'b1);
        end
        chk("valid after wake", 32'h1, output_valid);
        $display("test modes done");
        // Abort after ten falling edges must leave code and mode alone
        send(MODE_PD_1K, ~last_code, 32'h0000_0A04, 1'b0);
        chk("code after abort", last_code, dac_code);
        chk("mode after abort", MODE_NORMAL, op_mode);
        $display("test abort done");
        // Select idled low, then a frame straight after it
        send(MODE_NORMAL, 16'h0000, 32'h0000_0002, 1'b1);
        chk("select idles low", 32'h0, link_w.sync_n);
        apb(1'b0, REG_CTRL, 32'h0000_0000, r);
        chk("ctrl readback", 32'h0000_0002, r);
        send(MODE_NORMAL, 16'h1234, 32'h0000_0000, 1'b1);
        chk("notes left", 32'h0, notes.size());
        $display("test idle done");
        apb(1'b0, 32'h0000_0010, 32'h0000_0000, r);
        chk("unmapped read", 32'h0, r);
        apb(1'b0, REG_DATA, 32'h0000_0000, r);
        chk("data readback", {14'h0000, MODE_NORMAL, 16'h1234}, {14'h0000, r[17:0]});
        $display("test regs done");
        // Second reset in mid-run restores the power-up code
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("code after reset", CODE_ZERO, dac_code);
        $display("test rereset done");
        close_out;
    end
endmodule
